/* fspb_device.sv */
// flash self-program controller, device end
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - system reset mid-operation lets operation finish
// - erase, write, lock take 3.7-4.5ms
// - boot size selects boot region start
// - top 32 pages are no-read-while-write
// - program counter is 15 bits
// - page word index from Z7..Z1
// - page number from Z15..Z8
// - Z bit is one above pc bit
// - software keeps Z0 zero for commands
// - software zeroes word field on write
// - only upper area fetchable during lower-area erase or write
// - software re-enables area while busy set
// - software waits for enable bit clear
// - software waits for eeprom write end
// - software masks interrupts around command write
// - rewrite: erase, reenable, fill, write, reenable
// - no command writes while sleeping
// - boot lock refuses boot region updates
// - page write pattern then store within four
// - temp buffer clears on write, reenable, reset
module fspb_device import fspb_pkg::*; #(
	parameter int RC_DIV_P = RC_DIV,
	parameter int OP_TICKS_P = OP_TICKS
) (
	// clock and resets
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic porRst_n,
	// cpu side
	fspb_if.dev bus,
	// configuration straps
	input wire logic [1:0] bootSize,
	input wire logic bootLocked,
	// flash array side
	output logic progErase,
	output logic progWrite,
	output logic progLock,
	output logic [PAGE_W-1:0] progPage,
	output logic [7:0] lockData,
	input wire logic [WORD_W-1:0] bufAddr,
	output logic [15:0] bufData,
	output logic [PC_W-1:0] appEnd
);
	localparam int WW = $clog2(SPM_WINDOW);
	localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_AREA_PAGE = NO_READ_WHILE_WRITE_AREA_START[PC_W-1:WORD_W];

	// ------------------------------------------------------------
	// command window
	// ------------------------------------------------------------
	logic armed_q;
	logic [4:0] cmd_q;
	logic [WW-1:0] win_q;
	logic opRun_q;
	fspb_op_t opKind_q;
	logic [4:0] opCmd_q;
	logic rwwBusy_q;
	logic nrwwOp_q;
	logic enBit;
	logic cmdTake;
	logic spmHit;
	logic [PC_W-1:0] pcAddr;
	logic [PAGE_W-1:0] page_number_field;
	logic [WORD_W-1:0] in_page_word_field;
	logic bootHit;
	logic startEw;
	logic startLock;
	logic doReen;
	logic opDone;

	assign enBit = armed_q || opRun_q;
	// a sleeping core fetches nothing, so a write seen then is ignored
	assign cmdTake = bus.csrWr && !enBit && !bus.eeBusy
		&& !bus.sleeping;
	assign spmHit = armed_q && bus.spm;
	assign pcAddr = bus.zPtr[Z_PC_TOP:Z_WORD_LO];
	assign page_number_field = bus.zPtr[Z_PC_TOP:Z_PAGE_LO];
	assign in_page_word_field = bus.zPtr[Z_PAGE_TOP:Z_WORD_LO];
	assign bootHit = bootLocked
		&& (pcAddr >= bootStart(bootSize));
	assign startEw = spmHit && !bootHit
		&& (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE);
	assign startLock = spmHit && (cmd_q == CMD_LOCK);
	assign doReen = spmHit && (cmd_q == CMD_REEN);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
			cmd_q <= '0;
			win_q <= '0;
		end else if (cmdTake) begin
			armed_q <= 1'b1;
			cmd_q <= bus.csrWdata[4:0];
			win_q <= '0;
		end else if (armed_q) begin
			// unused window auto-clears the command
			if (spmHit || win_q == WW'(SPM_WINDOW - 1)) begin
				armed_q <= 1'b0;
			end
			win_q <= win_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// timed operation, survives system reset
	// ------------------------------------------------------------
	// only power-on resets this state: a system reset must not cut an
	// erase or write short and leave the array half programmed
	fspb_rc_timer #(
		.DIV(RC_DIV_P),
		.TICKS(OP_TICKS_P)
	) u_timer (
		.mclk(mclk),
		.porRst_n(porRst_n),
		.start(startEw || startLock),
		.done(opDone)
	);

	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			opRun_q <= 1'b0;
			opKind_q <= OP_NONE;
			opCmd_q <= '0;
			nrwwOp_q <= 1'b0;
			progPage <= '0;
			lockData <= '0;
		end else if (startEw || startLock) begin
			opRun_q <= 1'b1;
			opCmd_q <= cmd_q;
			opKind_q <= startLock ? OP_LOCK :
				(cmd_q == CMD_ERASE) ? OP_ERASE : OP_WRITE;
			nrwwOp_q <= !startLock && (page_number_field >= NO_READ_WHILE_WRITE_AREA_PAGE);
			progPage <= page_number_field;
			lockData <= bus.spmData[7:0];
		end else if (opDone) begin
			opRun_q <= 1'b0;
			opKind_q <= OP_NONE;
		end
	end

	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			progErase <= 1'b0;
			progWrite <= 1'b0;
			progLock <= 1'b0;
		end else begin
			progErase <= startEw && (cmd_q == CMD_ERASE);
			progWrite <= startEw && (cmd_q == CMD_WRITE);
			progLock <= startLock;
		end
	end

	// set wins: a new operation starting beats a same-cycle re-enable
	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			rwwBusy_q <= 1'b0;
		end else if (startEw) begin
			rwwBusy_q <= 1'b1;
		end else if (doReen && !opRun_q) begin
			rwwBusy_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// fetch gating
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			bus.rwwBlock <= 1'b0;
			bus.cpuHalt <= 1'b0;
		end else begin
			bus.rwwBlock <= rwwBusy_q;
			// programming the upper area leaves nothing safe to fetch
			bus.cpuHalt <= opRun_q && nrwwOp_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus.csrStatus <= '0;
		end else begin
			bus.csrStatus <= '0;
			bus.csrStatus[CSR_BUSY] <= rwwBusy_q;
			bus.csrStatus[CSR_EN] <= enBit;
			if (opRun_q) begin
				bus.csrStatus[CSR_REEN:CSR_ERS] <= opCmd_q[CSR_REEN:CSR_ERS];
			end else if (armed_q) begin
				bus.csrStatus[CSR_REEN:CSR_ERS] <= cmd_q[CSR_REEN:CSR_ERS];
			end
		end
	end

	// ------------------------------------------------------------
	// temporary page buffer
	// ------------------------------------------------------------
	logic [15:0] bufMem [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] bufValid_q;
	logic bufLoad;
	logic bufClr;

	// each word takes one load only until the buffer is cleared
	assign bufLoad = spmHit && (cmd_q == CMD_LOAD) && !bufValid_q[in_page_word_field];
	assign bufClr = doReen || (opDone && opKind_q == OP_WRITE);

	always_ff @(posedge mclk) begin
		if (bufLoad) begin
			bufMem[in_page_word_field] <= bus.spmData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bufValid_q <= '0;
		end else if (bufClr) begin
			bufValid_q <= '0;
		end else if (bufLoad) begin
			bufValid_q[in_page_word_field] <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bufData <= '0;
		end else begin
			bufData <= bufValid_q[bufAddr] ? bufMem[bufAddr] : 16'hFFFF;
		end
	end

	// ------------------------------------------------------------
	// region report
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			appEnd <= '0;
		end else begin
			appEnd <= bootStart(bootSize) - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* fspb_pkg.sv */
// shared constants, types and decoders for the flash self-program block
package fspb_pkg;

	// ------------------------------------------------------------
	// clocking and timed operation
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RC_PERIOD_NS = 1000;
	localparam int RC_DIV = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OP_MIN_US = 3700;
	localparam int OP_MAX_US = 4500;
	// nominal point inside the allowed band, leaves margin for rc drift
	localparam int OP_TYP_US = (OP_MIN_US + OP_MAX_US) / 2;
	localparam int OP_TICKS = OP_TYP_US * 1000 / RC_PERIOD_NS;
	localparam int SPM_WINDOW = 4;

	// ------------------------------------------------------------
	// addressing
	// ------------------------------------------------------------
	localparam int PC_W = 15;
	localparam int PAGE_W = 8;
	localparam int WORD_W = 7;
	localparam int PAGE_WORDS = 128;
	localparam int Z_PC_TOP = 15;
	localparam int Z_PAGE_LO = 8;
	localparam int Z_PAGE_TOP = 7;
	localparam int Z_WORD_LO = 1;
	localparam logic [PC_W-1:0] BOOT_START_11 = 15'h7E00;
	localparam logic [PC_W-1:0] BOOT_START_10 = 15'h7C00;
	localparam logic [PC_W-1:0] BOOT_START_01 = 15'h7800;
	localparam logic [PC_W-1:0] BOOT_START_00 = 15'h7000;
	localparam logic [PC_W-1:0] FLASH_TOP = 15'h7FFF;
	localparam logic [PC_W-1:0] NO_READ_WHILE_WRITE_AREA_START = 15'h7000;
	localparam int NO_READ_WHILE_WRITE_AREA_PAGES = 32;
	localparam int RWW_PAGES = 224;

	// ------------------------------------------------------------
	// store_prog_ctrl_status_reg layout and commands
	// ------------------------------------------------------------
	localparam int CSR_EN = 0;
	localparam int CSR_ERS = 1;
	localparam int CSR_WRT = 2;
	localparam int CSR_LOCK = 3;
	localparam int CSR_REEN = 4;
	localparam int CSR_BUSY = 6;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;

	// ------------------------------------------------------------
	// controller register map
	// ------------------------------------------------------------
	localparam logic [1:0] REG_CMD = 2'h0;
	localparam logic [1:0] REG_Z = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	localparam logic [1:0] REG_STAT = 2'h3;
	localparam int CMD_AUTO_REEN = 8;

	typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} fspb_op_t;

	function automatic logic [PC_W-1:0] bootStart(input logic [1:0] sel);
		case (sel)
			2'h3: bootStart = BOOT_START_11;
			2'h2: bootStart = BOOT_START_10;
			2'h1: bootStart = BOOT_START_01;
			default: bootStart = BOOT_START_00;
		endcase
	endfunction

endpackage

/* fspb_if.sv */
// link between the cpu core and the flash self-program controller
`timescale 1ns/10ps
`default_nettype none
interface fspb_if;
	logic csrWr;
	logic [7:0] csrWdata;
	logic spm;
	logic [15:0] zPtr;
	logic [15:0] spmData;
	logic eeBusy;
	logic sleeping;
	logic [7:0] csrStatus;
	logic rwwBlock;
	logic cpuHalt;

	modport dev(input csrWr, csrWdata, spm, zPtr, spmData, eeBusy, sleeping,
		output csrStatus, rwwBlock, cpuHalt);
	modport cpu(output csrWr, csrWdata, spm, zPtr, spmData, eeBusy, sleeping,
		input csrStatus, rwwBlock, cpuHalt);
endinterface
`default_nettype wire

/* fspb_rc_timer.sv */
// rc-paced duration timer for erase, write and lock operations
`timescale 1ns/10ps
`default_nettype none
module fspb_rc_timer #(
	parameter int DIV = 100,
	parameter int TICKS = 4100
) (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic porRst_n,
	// control
	input wire logic start,
	output logic done
);
	localparam int DW = $clog2(DIV + 1);
	localparam int TW = $clog2(TICKS + 1);

	logic running_q;
	logic [DW-1:0] div_q;
	logic [TW-1:0] ticks_q;
	logic rcTick;

	// rc rate as a one-cycle enable, so everything stays on mclk
	assign rcTick = running_q && (div_q == DW'(DIV - 1));

	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			div_q <= '0;
		end else if (!running_q || rcTick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			running_q <= 1'b0;
			ticks_q <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				running_q <= 1'b1;
				ticks_q <= '0;
			end else if (rcTick) begin
				if (ticks_q == TW'(TICKS - 1)) begin
					running_q <= 1'b0;
					done <= 1'b1;
				end
				ticks_q <= ticks_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* fspb_host.sv */
// flash self-program controller, cpu-core end issuing timed sequences
`timescale 1ns/10ps
`default_nettype none
module fspb_host import fspb_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// device side
	fspb_if.cpu bus,
	// register port
	input wire logic [1:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// system inputs and status
	input wire logic eeWriteActive,
	input wire logic sleepReq,
	output logic irqMasked
);
	typedef enum {H_IDLE, H_WAIT_EN, H_WAIT_EE, H_WRITE, H_SPM,
		H_CHECK} fspb_hstate_t;

	fspb_hstate_t state_q;
	logic [4:0] cmd_q;
	logic autoReen_q;
	logic [15:0] z_q;
	logic [15:0] data_q;
	logic goCmd;

	assign goCmd = regWr && (regAddr == REG_CMD) && (state_q == H_IDLE);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus.eeBusy <= 1'b0;
			bus.sleeping <= 1'b0;
		end else begin
			bus.eeBusy <= eeWriteActive;
			bus.sleeping <= sleepReq;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= '0;
		end else if (regWr && regAddr == REG_DATA) begin
			data_q <= regWdata;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= H_IDLE;
			cmd_q <= '0;
			autoReen_q <= 1'b0;
			z_q <= '0;
			irqMasked <= 1'b0;
			bus.csrWr <= 1'b0;
			bus.csrWdata <= '0;
			bus.spm <= 1'b0;
			bus.zPtr <= '0;
			bus.spmData <= '0;
		end else begin
			bus.csrWr <= 1'b0;
			bus.spm <= 1'b0;
			if (regWr && regAddr == REG_Z && state_q == H_IDLE) begin
				z_q <= regWdata;
			end
			case (state_q)
				H_IDLE: begin
					if (goCmd) begin
						cmd_q <= regWdata[4:0];
						autoReen_q <= regWdata[CMD_AUTO_REEN];
						state_q <= H_WAIT_EN;
					end
				end
				H_WAIT_EN: begin
					if (!bus.csrStatus[CSR_EN]) begin
						irqMasked <= 1'b1;
						state_q <= H_WAIT_EE;
					end
				end
				H_WAIT_EE: begin
					if (!bus.eeBusy && !bus.sleeping) begin
						bus.csrWr <= 1'b1;
						bus.csrWdata <= {3'h0, cmd_q};
						bus.zPtr <= {z_q[15:1], 1'b0};
						if (cmd_q == CMD_WRITE) begin
							bus.zPtr[Z_PAGE_TOP:0] <= '0;
						end
						bus.spmData <= data_q;
						state_q <= H_WRITE;
					end
				end
				H_WRITE: begin
					// store follows the command write directly
					bus.spm <= 1'b1;
					irqMasked <= 1'b0;
					state_q <= H_SPM;
				end
				H_SPM: begin
					if (cmd_q == CMD_LOAD) begin
						z_q <= z_q + 16'h0002;
					end
					if (autoReen_q && cmd_q != CMD_LOAD
						&& cmd_q != CMD_LOCK) begin
						state_q <= H_CHECK;
					end else begin
						state_q <= H_IDLE;
					end
				end
				H_CHECK: begin
					if (!bus.csrStatus[CSR_EN]) begin
						if (bus.csrStatus[CSR_BUSY]) begin
							cmd_q <= CMD_REEN;
							state_q <= H_WAIT_EN;
						end else begin
							state_q <= H_IDLE;
						end
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= '0;
		end else if (regRd) begin
			if (regAddr == REG_CMD) begin
				regRdata <= {7'h00, autoReen_q, 3'h0, cmd_q};
			end else if (regAddr == REG_Z) begin
				regRdata <= z_q;
			end else if (regAddr == REG_DATA) begin
				regRdata <= data_q;
			end else begin
				regRdata <= {7'h00, state_q != H_IDLE, bus.csrStatus};
			end
		end else begin
			regRdata <= '0;
		end
	end
endmodule
`default_nettype wire

/* fspb_link_sva.sv */
// concurrent checks on the link between the cpu-core and device ends
`timescale 1ns/10ps
`default_nettype none
module fspb_link_sva import fspb_pkg::*; #(
	parameter int RC_DIV_P = RC_DIV,
	parameter int OP_TICKS_P = OP_TICKS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// cpu to device
	input wire logic csrWr,
	input wire logic [7:0] csrWdata,
	input wire logic spm,
	input wire logic [15:0] zPtr,
	input wire logic eeBusy,
	input wire logic sleeping,
	// device to cpu
	input wire logic [7:0] csrStatus,
	input wire logic rwwBlock
);
	localparam int OP_CYC = RC_DIV_P * OP_TICKS_P;
	int enCnt;
	logic opFlag;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// too long for a repetition, so the enable run is counted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) enCnt <= 0;
		else enCnt <= csrStatus[CSR_EN] ? enCnt + 1 : 0;
	end
	// only runs that began with a real erase or write get a lower bound
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) opFlag <= 1'h0;
		else if ($rose(csrStatus[CSR_BUSY]) && $past(spm, 2)) opFlag <= 1'h1;
		else if (!csrStatus[CSR_EN]) opFlag <= 1'h0;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_enable_rise: assert property (csrWr && !csrStatus[CSR_EN] &&
		!eeBusy && !sleeping |-> ##2 csrStatus[CSR_EN])
		else $error("enable not raised after command write");
	a_ee_blocks: assert property (eeBusy && $past(eeBusy) |-> !csrWr)
		else $error("command write during eeprom write");
	a_sleep_blocks: assert property (
		sleeping && $past(sleeping) |-> !csrWr)
		else $error("command write while sleeping");
	a_spm_window: assert property (csrWr |-> ##[1:4] spm)
		else $error("store not issued within four cycles");
	a_z_even: assert property (spm |-> !zPtr[0])
		else $error("z bit 0 set on store");
	a_write_word_zero: assert property (
		csrWr && csrWdata[4:0] == CMD_WRITE ##1 spm |-> zPtr[7:1] == 7'h00)
		else $error("word field not zero on page write");
	a_rww_blocked: assert property (
		$rose(csrStatus[CSR_BUSY]) && $past(spm, 2) |-> rwwBlock)
		else $error("lower area readable during programming");
	a_enable_held: assert property (
		$rose(csrStatus[CSR_BUSY]) && $past(spm, 2) |-> csrStatus[CSR_EN][*8])
		else $error("enable dropped during operation");
	a_op_short: assert property (
		$fell(csrStatus[CSR_EN]) && opFlag |-> enCnt >= OP_CYC)
		else $error("operation ended too early");
	a_op_long: assert property (csrStatus[CSR_EN] |-> enCnt <= OP_CYC + 4)
		else $error("operation ran too long");
	a_reen_clears: assert property (csrWr && csrWdata[4:0] == CMD_REEN &&
		!csrStatus[CSR_EN] && !eeBusy && !sleeping ##1 spm
		|-> ##[1:3] !csrStatus[CSR_BUSY])
		else $error("busy flag not cleared by re-enable");
endmodule
`default_nettype wire

/* test_flash_self_program_boot_partition.sv */
// self-checking bench for the joined host and device ends
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module test_flash_self_program_boot_partition import fspb_pkg::*; ();
	localparam int DIVP = 2;
	localparam int TICKP = 5;
	localparam int LIMIT = 20000;
	logic mclk, rst_n, porRst_n, regWr, regRd, eeWriteActive, sleepReq;
	logic irqMasked, bootLocked, progErase, progWrite, progLock, haltSeen;
	logic [1:0] regAddr, bootSize;
	logic [15:0] regWdata, regRdata, bufData, s;
	logic [7:0] progPage, pg, lockData;
	logic [6:0] bufAddr, w;
	logic [14:0] appEnd;
	logic [15:0] dat [128];
	logic [31:0] seed;
	int n_mismatch, n_checks, cyc, nProg, nWr, i, k, n;

	// ------------------------------------------------------------
	// design pair and checker
	// ------------------------------------------------------------
	fspb_if link();
	fspb_host fspb_host_inst(.mclk(mclk), .rst_n(rst_n), .bus(link.cpu),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .eeWriteActive(eeWriteActive),
		.sleepReq(sleepReq), .irqMasked(irqMasked));
	fspb_device #(.RC_DIV_P(DIVP), .OP_TICKS_P(TICKP)) fspb_device_inst(
		.mclk(mclk), .rst_n(rst_n), .porRst_n(porRst_n), .bus(link.dev),
		.bootSize(bootSize), .bootLocked(bootLocked),
		.progErase(progErase), .progWrite(progWrite), .progLock(progLock),
		.progPage(progPage), .lockData(lockData), .bufAddr(bufAddr),
		.bufData(bufData), .appEnd(appEnd));
	fspb_link_sva #(.RC_DIV_P(DIVP), .OP_TICKS_P(TICKP)) fspb_link_sva_inst(
		.mclk(mclk), .rst_n(rst_n), .csrWr(link.csrWr),
		.csrWdata(link.csrWdata), .spm(link.spm), .zPtr(link.zPtr),
		.eeBusy(link.eeBusy), .sleeping(link.sleeping),
		.csrStatus(link.csrStatus), .rwwBlock(link.rwwBlock));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xrand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [14:0] expEnd(input logic [1:0] sel);
		case (sel)
			2'h3: return 15'h7DFF;
			2'h2: return 15'h7BFF;
			2'h1: return 15'h77FF;
			default: return 15'h6FFF;
		endcase
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic regWrite(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge mclk);
		regWr <= 1'h0;
	endtask
	task automatic regRead(input logic [1:0] a, output logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge mclk);
		regRd <= 1'h0;
		#1 d = regRdata;
	endtask
	// polls status; a stuck host counts as a mismatch
	task automatic waitIdle();
		logic [15:0] st;
		int t;
		t = 0;
		regRead(REG_STAT, st);
		while ((st[8] !== 1'h0 || st[CSR_EN] !== 1'h0) && t < 300) begin
			regRead(REG_STAT, st);
			t++;
		end
		`CHK("idle", 1'h1, 1'(t < 300))
	endtask
	// c[5] asks for the automatic re-enable, c[4:0] is the command code
	task automatic doCmd(input logic [15:0] z, d, input logic [5:0] c);
		waitIdle();
		regWrite(REG_Z, z);
		regWrite(REG_DATA, d);
		regWrite(REG_CMD, {7'h00, c[5], 3'h0, c[4:0]});
		waitIdle();
	endtask
	task automatic chkBuf(input logic [6:0] a, input logic [15:0] e);
		@(posedge mclk);
		bufAddr <= a;
		repeat (2) @(posedge mclk);
		#1 `CHK("bufData", e, bufData)
	endtask

	// ------------------------------------------------------------
	// clock and monitor
	// ------------------------------------------------------------
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	// sampled on the falling edge so registered outputs have settled
	always @(negedge mclk) begin
		cyc++;
		if (progErase || progWrite || progLock) nProg++;
		if (progWrite === 1'h1) nWr++;
		if (link.cpuHalt === 1'h1) haltSeen = 1'h1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 32'h0000000C;
		{rst_n, porRst_n, regWr, regRd, eeWriteActive, sleepReq} = 6'h00;
		{bootLocked, haltSeen, regAddr, regWdata, bootSize, bufAddr} = '0;
		for (i = 0; i < 128; i++) dat[i] = 16'hFFFF;
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		porRst_n <= 1'h1;
		for (k = 0; k < 4; k++) begin
			bootSize <= k[1:0];
			repeat (3) @(posedge mclk);
			#1 `CHK("appEnd", expEnd(k[1:0]), appEnd)
		end
		// buffer fill: both ends of the page and a repeated word
		pg = 8'(xrand() % 224);
		for (i = 0; i < 6; i++) begin
			w = (i == 0) ? 7'h00 : (i == 1 || i == 5) ? 7'h7F : 7'(xrand());
			s = 16'(xrand());
			if (dat[w] === 16'hFFFF) dat[w] = s;
			doCmd({pg, w, 1'h0}, s, {1'h0, CMD_LOAD});
		end
		for (i = 0; i < 128; i++) chkBuf(7'(i), dat[i]);
		doCmd({pg, 8'h00}, 16'h0000, {1'h0, CMD_WRITE});
		`CHK("progPage", pg, progPage)
		`CHK("nWr", 1, nWr)
		regRead(REG_STAT, s);
		`CHK("busy", 1'h1, s[CSR_BUSY])
		chkBuf(7'h7F, 16'hFFFF);
		doCmd(16'h0000, 16'h0000, {1'h0, CMD_REEN});
		regWrite(REG_STAT, 16'hFFFF);
		regRead(REG_STAT, s);
		`CHK("stat", 3'h0, {s[8], s[CSR_BUSY], s[CSR_EN]})
		`CHK("halt", 1'h0, haltSeen)
		// erases around the area boundary, auto re-enable
		for (k = 0; k < 4; k++) begin
			pg = (k == 3) ? 8'(xrand()) : (k == 2) ? 8'hFF : 8'hDF + 8'(k);
			haltSeen = 1'h0;
			doCmd({pg, 8'h00}, 16'h0000, {1'h1, CMD_ERASE});
			regRead(REG_STAT, s);
			`CHK("progPage", pg, progPage)
			`CHK("halt", pg >= 8'hE0, haltSeen)
			`CHK("busy", 1'h0, s[CSR_BUSY])
		end
		bootLocked <= 1'h1;
		for (k = 0; k < 2; k++) begin
			n = nProg;
			doCmd({8'hFC - 8'(k), 8'h00}, 16'h0000, {1'h1, CMD_ERASE});
			`CHK("nProg", n + k, nProg)
		end
		bootLocked <= 1'h0;
		pg = 8'(xrand());
		doCmd(16'h0000, {8'h00, pg}, {1'h0, CMD_LOCK});
		`CHK("lockData", pg, lockData)
		// eeprom write, then sleep, stall the command
		for (k = 0; k < 2; k++) begin
			n = nProg;
			eeWriteActive <= (k == 0);
			sleepReq <= (k == 1);
			regWrite(REG_Z, 16'h1000);
			regWrite(REG_CMD, {11'h008, CMD_ERASE});
			repeat (30) @(posedge mclk);
			#1 `CHK("nProg", n, nProg)
			`CHK("irqMasked", 1'h1, irqMasked)
			eeWriteActive <= 1'h0;
			sleepReq <= 1'h0;
			waitIdle();
			`CHK("nProg", n + 1, nProg)
			`CHK("irqMasked", 1'h0, irqMasked)
		end
		// system reset in mid-erase
		doCmd(16'h0006, 16'h1234, {1'h0, CMD_LOAD});
		n = nProg;
		regWrite(REG_Z, 16'h2000);
		regWrite(REG_CMD, {11'h000, CMD_ERASE});
		repeat (8) @(posedge mclk);
		rst_n <= 1'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (30) @(posedge mclk);
		regRead(REG_STAT, s);
		`CHK("nProg", n + 1, nProg)
		`CHK("busy", 1'h1, s[CSR_BUSY])
		chkBuf(7'h03, 16'hFFFF);
		doCmd(16'h0000, 16'h0000, {1'h0, CMD_REEN});
		end_sim();
	end
endmodule
`default_nettype wire
